/* File: inc/wdog_pkg.sv */
// shared constants and carriers for the windowed watchdog
// assumes one system clock; the slow count clock arrives as a plain pin
package wdog_pkg;
  // control byte layout
  localparam int WINDOW_MSB = 7;
  localparam int WINDOW_LSB = 4;
  localparam int PERIOD_MSB = 3;
  localparam int PERIOD_LSB = 0;
  // status byte layout
  localparam int LOCK_BIT = 7;
  localparam int BUSY_BIT = 0;
  // codes and reset values
  localparam logic [3:0] CODE_OFF = 4'h0;
  localparam logic [3:0] CODE_MIN = 4'h1;
  localparam logic [3:0] CODE_MAX = 4'hb;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // timing
  localparam int SLOW_CLK_HZ = 1024;
  localparam logic [13:0] BASE_CYCLES = 14'h0008;
  localparam int COUNT_W = 14;
  localparam logic [2:0] GUARD_INSTRS = 3'h4;
  localparam logic [1:0] SYNC_TICKS = 2'h2;
  // arbitrary neutral unlock key
  localparam logic [7:0] IO_KEY_DEFAULT = 8'h5a;

  typedef struct packed {
    logic [3:0] window;
    logic [3:0] period;
  } ctrl_type;

  typedef enum logic [2:0] {
    ST_OFF, ST_NORMAL, ST_FIRST, ST_CLOSED, ST_OPEN, ST_HALT
  } wd_state_type;
endpackage : wdog_pkg

/* File: src/windowed_watchdog_timer.sv */
// windowed watchdog: guarded control byte, lock, synced settings, restart
// assumes cpu-side pulses on MCLK; slow clock and fuse come from outside
// How it works
// - period field 1..b runs the watchdog; zero or a reserved code keeps it off
// - counter advances on edges of the 1.024 kHz slow clock
// - normal mode: no restart before time-out requests system reset
// - each accepted restart clears the count, new time-out begins
// - eleven time-outs from 8 ms to 8 s by period field
// - window field zero or reserved is normal mode, 1..b selects window mode
// - restart inside closed period requests a system reset
// - open period follows closed period; missed restart then resets
// - after window enable or debug exit, windows start at first restart
// - lock blocks control changes; set-only except during debug halt
// - control loads from boot fuse; nonzero period sets lock
// - keeps counting in all sleep modes while slow clock runs
// - independent clock lets reset request follow even without cpu
// - debug halt stops operation and clears the counter
// - leaving debug in window mode runs one normal time-out first
// - control writes are synced to slow domain; busy flag shows it
// - restart takes effect on the second slow clock edge after it, one to two cycles later
// - protected write needs key then write within four instructions
// - control and lock are guarded; busy flag is not
// - control: window 7:4, period 3:0; status: lock 7, busy 0
// - codes 1..b select 8..8k slow cycles; zero off, rest reserved
`timescale 1ns/10ps
module windowed_watchdog_timer #(
  parameter logic [7:0] IO_KEY = wdog_pkg::IO_KEY_DEFAULT
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic ARST_N,
  // slow count clock pin
  input wire logic SLOW_COUNT_CLOCK,
  // boot configuration
  input wire logic [7:0] BOOT_CONFIG_FUSE,
  // cpu side
  input wire logic DEBUG_HALT,
  input wire logic INSTR_DONE,
  input wire logic GUARD_WRITE,
  input wire logic [7:0] GUARD_DATA,
  input wire logic CTRL_WRITE,
  input wire logic [7:0] CTRL_DATA,
  input wire logic STATUS_WRITE,
  input wire logic [7:0] STATUS_DATA,
  input wire logic RESTART_INSTR,
  // readback and reset request
  output logic [7:0] CONTROL_A,
  output logic [7:0] WATCHDOG_STATUS,
  output logic SYS_RESET_REQ
);
  // slow clock synchroniser; edge found only past the second flop
  // tick lags the pin by one to two mclk cycles
  logic slow_meta_reg, slow_sync_reg, slow_last_reg;
  logic tick;
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      slow_meta_reg <= 1'b0;
      slow_sync_reg <= 1'b0;
      slow_last_reg <= 1'b0;
    end else begin
      slow_meta_reg <= SLOW_COUNT_CLOCK;
      slow_sync_reg <= slow_meta_reg;
      slow_last_reg <= slow_sync_reg;
    end
  end
  assign tick = slow_sync_reg & ~slow_last_reg;

  // time-out length of a code, zero for off or reserved
  function automatic logic [13:0] code_cycles(input logic [3:0] code);
    logic [13:0] r;
    r = 14'h0000;
    if (code >= wdog_pkg::CODE_MIN && code <= wdog_pkg::CODE_MAX) begin
      r = wdog_pkg::BASE_CYCLES << (code - wdog_pkg::CODE_MIN);
    end
    return r;
  endfunction : code_cycles

  // state a fresh time-out starts in: new setting, debug exit, reset pulse
  // reserved window codes fall back to normal mode, never a closed period
  // of zero length that no restart could survive
  function automatic wdog_pkg::wd_state_type fresh_state(
      input wdog_pkg::ctrl_type setting);
    wdog_pkg::wd_state_type s;
    if (code_cycles(setting.period) == 14'h0000) begin
      s = wdog_pkg::ST_OFF;
    end else if (code_cycles(setting.window) != 14'h0000) begin
      s = wdog_pkg::ST_FIRST;
    end else begin
      s = wdog_pkg::ST_NORMAL;
    end
    return s;
  endfunction : fresh_state

  wdog_pkg::ctrl_type ctrl_reg, ctrl_next, live_reg, live_next;
  logic lock_reg, lock_next;
  logic booted_reg, booted_next;
  logic [2:0] guard_reg, guard_next;
  logic busy_reg, busy_next;
  logic [1:0] busy_ticks_reg, busy_ticks_next;
  logic rst_pend_reg, rst_pend_next;
  logic [1:0] rst_ticks_reg, rst_ticks_next;
  wdog_pkg::wd_state_type state_reg, state_next;
  logic [13:0] count_reg, count_next;
  logic pulse_reg, pulse_next;
  logic unlocked, restart_now, apply_now;
  logic [13:0] open_len, closed_len;
  wdog_pkg::wd_state_type run_state;

  assign open_len = code_cycles(live_reg.period);
  assign closed_len = code_cycles(live_reg.window);
  assign unlocked = (guard_reg != 3'h0);

  always_comb begin
    ctrl_next = ctrl_reg;
    lock_next = lock_reg;
    booted_next = 1'b1;
    guard_next = guard_reg;
    busy_next = busy_reg;
    busy_ticks_next = busy_ticks_reg;
    rst_pend_next = rst_pend_reg;
    rst_ticks_next = rst_ticks_reg;
    live_next = live_reg;
    state_next = state_reg;
    count_next = count_reg;
    pulse_next = 1'b0;
    restart_now = 1'b0;
    apply_now = 1'b0;

    // guarded window: key opens it, instructions close it
    if (GUARD_WRITE && GUARD_DATA == IO_KEY) begin
      guard_next = wdog_pkg::GUARD_INSTRS;
    end else if (INSTR_DONE && guard_reg != 3'h0) begin
      guard_next = guard_reg - 3'h1;
    end

    if (!booted_reg) begin
      // fuse caught on the first edge after reset release
      ctrl_next = wdog_pkg::ctrl_type'(BOOT_CONFIG_FUSE);
      lock_next = (BOOT_CONFIG_FUSE[wdog_pkg::PERIOD_MSB:
                   wdog_pkg::PERIOD_LSB] != wdog_pkg::CODE_OFF);
      busy_next = 1'b1;
      busy_ticks_next = 2'h0;
    end else begin
      // busy flag itself is never guarded
      if (CTRL_WRITE && unlocked && !lock_reg) begin
        ctrl_next = wdog_pkg::ctrl_type'(CTRL_DATA);
        busy_next = 1'b1;
        busy_ticks_next = 2'h0;
      end
      if (STATUS_WRITE && unlocked) begin
        if (STATUS_DATA[wdog_pkg::LOCK_BIT]) begin
          lock_next = 1'b1;
        end else if (DEBUG_HALT) begin
          lock_next = 1'b0;
        end
      end
    end

    // settings reach the count logic on the second slow edge
    if (busy_reg && tick && !(CTRL_WRITE && unlocked && !lock_reg)) begin
      if (busy_ticks_reg == wdog_pkg::SYNC_TICKS - 2'h1) begin
        busy_next = 1'b0;
        live_next = ctrl_reg;
        apply_now = 1'b1;
      end else begin
        busy_ticks_next = busy_ticks_reg + 2'h1;
      end
    end

    // restart pulse synced over two slow edges
    if (rst_pend_reg && tick) begin
      if (rst_ticks_reg == wdog_pkg::SYNC_TICKS - 2'h1) begin
        rst_pend_next = 1'b0;
        rst_ticks_next = 2'h0;
        restart_now = 1'b1;
      end else begin
        rst_ticks_next = rst_ticks_reg + 2'h1;
      end
    end
    if (RESTART_INSTR) begin
      rst_pend_next = 1'b1;
      if (!rst_pend_reg || restart_now) begin
        rst_ticks_next = 2'h0;
      end
    end

    // mode of a fresh time-out comes from the setting about to apply,
    // so a newly synced change starts in its own mode at once
    run_state = fresh_state(live_next);

    // count state; runs in any sleep mode while the slow clock toggles
    if (DEBUG_HALT) begin
      state_next = wdog_pkg::ST_HALT;
      count_next = 14'h0000;
    end else if (apply_now) begin
      state_next = run_state;
      count_next = 14'h0000;
    end else begin
      unique case (state_reg)
        wdog_pkg::ST_OFF: begin
          count_next = 14'h0000;
        end
        wdog_pkg::ST_HALT: begin
          state_next = run_state;
          count_next = 14'h0000;
        end
        wdog_pkg::ST_NORMAL, wdog_pkg::ST_FIRST: begin
          if (restart_now) begin
            count_next = 14'h0000;
            if (state_reg == wdog_pkg::ST_FIRST) begin
              state_next = wdog_pkg::ST_CLOSED;
            end
          end else if (tick) begin
            if (count_reg == open_len - 14'h0001) begin
              pulse_next = 1'b1;
              count_next = 14'h0000;
            end else begin
              count_next = count_reg + 14'h0001;
            end
          end
        end
        wdog_pkg::ST_CLOSED: begin
          if (restart_now) begin
            pulse_next = 1'b1;
            state_next = run_state;
            count_next = 14'h0000;
          end else if (tick) begin
            if (count_reg == closed_len - 14'h0001) begin
              state_next = wdog_pkg::ST_OPEN;
              count_next = 14'h0000;
            end else begin
              count_next = count_reg + 14'h0001;
            end
          end
        end
        wdog_pkg::ST_OPEN: begin
          if (restart_now) begin
            state_next = wdog_pkg::ST_CLOSED;
            count_next = 14'h0000;
          end else if (tick) begin
            if (count_reg == open_len - 14'h0001) begin
              pulse_next = 1'b1;
              state_next = run_state;
              count_next = 14'h0000;
            end else begin
              count_next = count_reg + 14'h0001;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl_reg <= wdog_pkg::ctrl_type'(wdog_pkg::CTRL_RESET);
      live_reg <= wdog_pkg::ctrl_type'(wdog_pkg::CTRL_RESET);
      lock_reg <= 1'b0;
      booted_reg <= 1'b0;
      guard_reg <= 3'h0;
      busy_reg <= 1'b0;
      busy_ticks_reg <= 2'h0;
      rst_pend_reg <= 1'b0;
      rst_ticks_reg <= 2'h0;
      state_reg <= wdog_pkg::ST_OFF;
      count_reg <= 14'h0000;
      pulse_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      live_reg <= live_next;
      lock_reg <= lock_next;
      booted_reg <= booted_next;
      guard_reg <= guard_next;
      busy_reg <= busy_next;
      busy_ticks_reg <= busy_ticks_next;
      rst_pend_reg <= rst_pend_next;
      rst_ticks_reg <= rst_ticks_next;
      state_reg <= state_next;
      count_reg <= count_next;
      pulse_reg <= pulse_next;
    end
  end

  // readback; status layout fixed, other bits zero
  assign CONTROL_A = ctrl_reg;
  genvar b;
  generate
    for (b = 0; b < 8; b = b + 1) begin : g_status
      if (b == wdog_pkg::LOCK_BIT) begin : g_lock
        assign WATCHDOG_STATUS[b] = lock_reg;
      end else if (b == wdog_pkg::BUSY_BIT) begin : g_busy
        assign WATCHDOG_STATUS[b] = busy_reg;
      end else begin : g_spare
        // spare positions read as their reset value
        assign WATCHDOG_STATUS[b] = wdog_pkg::STATUS_RESET[b];
      end
    end
  endgenerate
  assign SYS_RESET_REQ = pulse_reg;
endmodule : windowed_watchdog_timer

/* File: verif/cpu_model.sv */
// cpu stand-in: guarded writes and restart pulses
// assumes tasks are entered just after a rising clk edge
`timescale 1ns/10ps
module cpu_model #(
  parameter logic [7:0] KEY = wdog_pkg::IO_KEY_DEFAULT
) (
  // clock
  input wire logic clk,
  // strobes and data
  output logic instr_done,
  output logic guard_write,
  output logic [7:0] guard_data,
  output logic ctrl_write,
  output logic [7:0] ctrl_data,
  output logic status_write,
  output logic [7:0] status_data,
  output logic restart_instr
);
  initial begin
    {instr_done, guard_write, ctrl_write, status_write} = 4'h0;
    restart_instr = 1'b0;
    {guard_data, ctrl_data, status_data} = 24'h000000;
  end
  // one instruction retires every other cycle, so an unused guard
  // window closes by itself
  always @(posedge clk) instr_done <= ~instr_done;
  // key, then the write as next instruction, inside four
  task automatic wr(input logic st, key, input logic [7:0] d);
    if (key) begin
      guard_write <= 1'b1;
      guard_data <= KEY;
      @(posedge clk);
      guard_write <= 1'b0;
      guard_data <= ~KEY;
    end
    ctrl_write <= !st;
    status_write <= st;
    ctrl_data <= d;
    status_data <= d;
    @(posedge clk);
    {ctrl_write, status_write} <= 2'h0;
    ctrl_data <= ~d;
    status_data <= ~d;
  endtask : wr
  task automatic restart;
    restart_instr <= 1'b1;
    @(posedge clk);
    restart_instr <= 1'b0;
  endtask : restart
endmodule : cpu_model

/* File: verif/tb.sv */
// bench: guard, lock, normal and window time-outs
// assumes slow clock far above 1.024 kHz to keep runs short
`timescale 1ns/10ps
module tb;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic slow = 1'b0;
  logic halt = 1'b0;
  logic [7:0] fuse = 8'h01;
  logic inst, gw, cw, sw, rs, req, exp_pulse;
  logic [7:0] gd, cd, sd, ctrl, stat;
  int n_mismatch = 0;
  int cmp_count = 0;
  int seed = 89;
  logic q[$];
  initial forever #4 mclk = ~mclk;
  // odd half period still puts every fourth slow edge on an mclk edge
  initial forever #47 slow = ~slow;
  windowed_watchdog_timer windowed_watchdog_timer_inst (.MCLK(mclk),
    .ARST_N(arst_n), .SLOW_COUNT_CLOCK(slow), .BOOT_CONFIG_FUSE(fuse),
    .DEBUG_HALT(halt), .INSTR_DONE(inst), .GUARD_WRITE(gw),
    .GUARD_DATA(gd), .CTRL_WRITE(cw), .CTRL_DATA(cd), .STATUS_WRITE(sw),
    .STATUS_DATA(sd), .RESTART_INSTR(rs), .CONTROL_A(ctrl),
    .WATCHDOG_STATUS(stat), .SYS_RESET_REQ(req));
  cpu_model cpu_model_inst (.clk(mclk), .instr_done(inst),
    .guard_write(gw), .guard_data(gd), .ctrl_write(cw), .ctrl_data(cd),
    .status_write(sw), .status_data(sd), .restart_instr(rs));
  task automatic check(input string what, input logic [15:0] exp, seen);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  task automatic wait_busy;
    int i;
    for (i = 0; i < 100 && stat[0] !== 1'b0; i++) @(posedge mclk);
    @(posedge mclk);
    if (i == 100) begin
      n_mismatch++;
      give_verdict();
    end
  endtask : wait_busy
  task automatic put(input logic st, key, input logic [7:0] d,
      input logic [15:0] exp);
    wait_busy();
    cpu_model_inst.wr(st, key, d);
    @(negedge mclk);
    check("control and status", exp, {ctrl, stat});
  endtask : put
  task automatic expect_reset(input int quiet, lim);
    int i;
    repeat (quiet) @(posedge mclk);
    q.push_back(1'b1);
    for (i = 0; i < lim && q.size() != 0; i++) @(posedge mclk);
    if (q.size() != 0) begin
      n_mismatch++;
      give_verdict();
    end
  endtask : expect_reset
  // any pulse with no note pending is a spurious reset
  always @(negedge mclk) begin
    if (req === 1'b1) begin
      exp_pulse = (q.size() != 0) ? q.pop_front() : 1'b0;
      check("reset pulse", {15'h0, exp_pulse}, {15'h0, req});
    end
  end
  initial begin
    int n;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    @(negedge mclk);
    @(negedge mclk);
    check("boot state", 16'h0181, {ctrl, stat});
    @(posedge mclk);
    halt <= 1'b1;
    put(0, 1, 8'h03, 16'h0180);
    put(1, 1, 8'h00, 16'h0100);
    repeat (200) @(posedge mclk); // counter kept cleared while halted
    halt <= 1'b0;
    put(0, 0, 8'h02, 16'h0100);
    for (int c = 1; c < 8; c++) begin
      n = 8 << (c - 1);
      put(0, 1, {4'h0, c[3:0]}, {4'h0, c[3:0], 8'h01});
      wait_busy();
      repeat (4) begin
        cpu_model_inst.restart();
        repeat (30 + {$random(seed)} % 30) @(posedge mclk);
      end
      cpu_model_inst.restart();
      expect_reset(n * 47 / 4 + 4, 60);
    end
    put(0, 1, 8'h11, 16'h1101);
    wait_busy();
    cpu_model_inst.restart();
    repeat (36) @(posedge mclk);
    cpu_model_inst.restart();
    expect_reset(0, 70);
    cpu_model_inst.restart();
    repeat (118) @(posedge mclk);
    cpu_model_inst.restart();
    expect_reset(188, 60);
    put(0, 1, 8'h00, 16'h0001);
    repeat (300) @(posedge mclk);
    put(1, 1, 8'h80, 16'h0080);
    put(1, 1, 8'h00, 16'h0080);
    give_verdict();
  end
endmodule : tb
bind windowed_watchdog_timer wdog_asserts wdog_asserts_inst (.MCLK(MCLK),
  .ARST_N(ARST_N), .DEBUG_HALT(DEBUG_HALT), .CTRL_WRITE(CTRL_WRITE),
  .STATUS_WRITE(STATUS_WRITE), .STATUS_DATA(STATUS_DATA),
  .CONTROL_A(CONTROL_A), .WATCHDOG_STATUS(WATCHDOG_STATUS),
  .SYS_RESET_REQ(SYS_RESET_REQ));

/* File: verif/wdog_asserts.sv */
// port checks for the windowed watchdog
// assumes a bind onto its top; slow tick near 12 mclk
`timescale 1ns/10ps
module wdog_asserts (
  // clock and reset
  input wire logic MCLK,
  input wire logic ARST_N,
  // cpu side
  input wire logic DEBUG_HALT,
  input wire logic CTRL_WRITE,
  input wire logic STATUS_WRITE,
  input wire logic [7:0] STATUS_DATA,
  // outputs
  input wire logic [7:0] CONTROL_A,
  input wire logic [7:0] WATCHDOG_STATUS,
  input wire logic SYS_RESET_REQ
);
  logic lock, busy, set_bit;
  assign lock = WATCHDOG_STATUS[7];
  assign busy = WATCHDOG_STATUS[0];
  assign set_bit = STATUS_DATA[7];
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!ARST_N);
  property p_pulse; SYS_RESET_REQ |=> !SYS_RESET_REQ [*8]; endproperty
  a_pulse: assert property (p_pulse)
    else $error("reset request too long");
  property p_off;
    (CONTROL_A[3:0] == 4'h0 && !busy) [*2] |-> !SYS_RESET_REQ;
  endproperty
  a_off: assert property (p_off)
    else $error("reset request while off");
  property p_status; WATCHDOG_STATUS[6:1] == 6'h00; endproperty
  a_status: assert property (p_status)
    else $error("status spare bits set");
  property p_ctrl_src;
    $past(ARST_N, 2) && $changed(CONTROL_A) |-> $past(CTRL_WRITE) &&
      !$past(lock) && busy;
  endproperty
  a_ctrl_src: assert property (p_ctrl_src)
    else $error("control changed without an unlocked write");
  // bound assumes the bench's fast slow clock
  property p_busy_end; $rose(busy) |-> ##[1:40] !busy; endproperty
  a_busy_end: assert property (p_busy_end)
    else $error("busy flag stuck");
  property p_lock_clr;
    $fell(lock) |-> $past(DEBUG_HALT) && $past(STATUS_WRITE);
  endproperty
  a_lock_clr: assert property (p_lock_clr)
    else $error("lock cleared outside debug halt");
  property p_lock_set;
    $past(ARST_N, 2) && $rose(lock) |-> $past(STATUS_WRITE) &&
      $past(set_bit);
  endproperty
  a_lock_set: assert property (p_lock_set)
    else $error("lock set without a status write");
  property p_boot;
    $past(ARST_N) && !$past(ARST_N, 2) |->
      busy && lock == (CONTROL_A[3:0] != 4'h0);
  endproperty
  a_boot: assert property (p_boot)
    else $error("boot lock wrong");
  c_reset: cover property (SYS_RESET_REQ);
  c_unlock: cover property ($fell(lock));
  c_sync: cover property ($fell(busy));
endmodule : wdog_asserts
